//--- verilog/soft_reset_params.svh
// Register offsets, field layout and reset values of the peripheral soft reset sequencer
`ifndef SOFT_RESET_PARAMS_SVH
`define SOFT_RESET_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CYCLE_COUNT_IDX 16'h1C04
`define RESET_CONTROL_IDX 16'h1C05

// ----------------------------------------------------------------
// Field layout of the control register
// ----------------------------------------------------------------
`define GROUP_FOUR_BIT 7
`define GROUP_THREE_BIT 5
`define DMA_GROUP_BIT 4
`define USB_GROUP_BIT 3
`define ANALOG_GROUP_BIT 2
`define TIMER_GROUP_BIT 1
`define I2C_GROUP_BIT 0
`define GROUP_BITS_MASK 8'hBF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CYCLE_COUNT_RESET 16'h0008
`define GROUP_BITS_RESET 8'h00
`define RDATA_RESET 32'h0000_0000
`define COUNT_ONE 16'h0001

`endif

//--- verilog/soft_reset_pkg.sv
// Types shared by the peripheral soft reset sequencer
package soft_reset_pkg;

  // State of the countdown module
  typedef struct packed {
    logic [15:0] value;
  } countdown_state_t;

  // State of the sequencer top
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] groups;
    logic [31:0] rdata;
  } sequencer_state_t;

endpackage : soft_reset_pkg

//--- verilog/reset_countdown.sv
// Down-counter that times how long the group reset lines stay asserted
`timescale 1ns/100ps
`include "soft_reset_params.svh"

module reset_countdown
  import soft_reset_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic step,
  // Status
  output logic [15:0] value,
  output logic at_one
);

  countdown_state_t state_q;
  countdown_state_t state_d;

  // ----------------------------------------------------------------
  // Next state: load wins over step, never wraps below zero
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (load) begin
      state_d.value = load_value;
    end else if (step && state_q.value != 16'h0000) begin
      state_d.value = state_q.value - `COUNT_ONE;
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q.value <= 16'h0000;
    end else begin
      state_q <= state_d;
    end
  end

  assign value = state_q.value;
  assign at_one = (state_q.value <= `COUNT_ONE); // Zero counts as last cycle too

endmodule : reset_countdown

//--- verilog/peripheral_soft_reset_ctrl.sv
// Software-triggered peripheral group reset sequencer with an APB register port
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "soft_reset_params.svh"

// How it works
// - Triggered group reset lines are held low for the programmed cycle count.
// - The count register holds one 16-bit count in bits 15 to 0.
// - When the countdown reaches zero the active group bits clear, releasing resets.
// - Writing 1 to a control bit starts the reset of that group.
// - Groups stay in reset for the programmed number of cycles after the latest trigger.
// - Reading the control register shows the live state of each group reset.
// - One bit may reset several peripherals; group four covers four peripherals.
// - Count register sits at index 1C04h, control register at index 1C05h.
// - Bit 7 is group four, bit 5 group three, bit 4 DMA.
// - Bit 3 is USB, bit 2 analog, bit 1 timers, bit 0 I2C.
// - Writing 0 does nothing; reserved bits 15 to 8 and 6 read zero.
module peripheral_soft_reset_ctrl
  import soft_reset_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Group reset lines to the peripherals, active low
  output logic group_four_reset_b,
  output logic group_three_reset_b,
  output logic dma_reset_b,
  output logic usb_reset_b,
  output logic analog_group_reset_b,
  output logic timer_group_reset_b,
  output logic i2c_reset_b
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] idx);
    reg_hit = (addr == {idx[13:0], 2'b00});
  endfunction : reg_hit

  sequencer_state_t state_q;
  sequencer_state_t state_d;
  logic hit_count;
  logic hit_control;
  logic wr_access;
  logic trigger;
  logic any_active;
  logic [7:0] new_groups;
  logic [15:0] cnt_value;
  logic cnt_last;

  assign hit_count = reg_hit(paddr, `CYCLE_COUNT_IDX);
  assign hit_control = reg_hit(paddr, `RESET_CONTROL_IDX);
  assign wr_access = psel && penable && pwrite;
  // Only ones start a reset, zeros and reserved bits are dropped
  assign new_groups = pwdata[7:0] & `GROUP_BITS_MASK;
  assign trigger = wr_access && hit_control && (new_groups != 8'h00);
  assign any_active = (state_q.groups != 8'h00);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_count || hit_control);
  assign prdata = state_q.rdata;

  // ----------------------------------------------------------------
  // Countdown timer
  // ----------------------------------------------------------------
  reset_countdown countdown (
    .clk(clk),
    .rst_b(rst_b),
    .load(trigger),
    .load_value(state_q.count),
    .step(any_active),
    .value(cnt_value),
    .at_one(cnt_last)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A retrigger reloads the current count for all groups; a lower rewritten count can shorten one
  always_comb begin
    state_d = state_q;
    if (wr_access && hit_count) begin
      state_d.count = pwdata[15:0];
    end
    if (trigger) begin
      state_d.groups = state_q.groups | new_groups;
    end else if (any_active && cnt_last) begin
      state_d.groups = `GROUP_BITS_RESET;
    end
    // Read data is captured in the setup phase so it comes from a flop
    if (psel && !penable && !pwrite) begin
      if (hit_count) begin
        state_d.rdata = {16'h0000, state_q.count};
      end else if (hit_control) begin
        state_d.rdata = {24'h00_0000, state_q.groups};
      end else begin
        state_d.rdata = `RDATA_RESET;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q.count <= `CYCLE_COUNT_RESET;
      state_q.groups <= `GROUP_BITS_RESET;
      state_q.rdata <= `RDATA_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Group reset lines
  // ----------------------------------------------------------------
  // Group four fans out to both audio serial ports, UART and SPI
  assign group_four_reset_b = !state_q.groups[`GROUP_FOUR_BIT];
  assign group_three_reset_b = !state_q.groups[`GROUP_THREE_BIT];
  assign dma_reset_b = !state_q.groups[`DMA_GROUP_BIT];
  assign usb_reset_b = !state_q.groups[`USB_GROUP_BIT];
  assign analog_group_reset_b = !state_q.groups[`ANALOG_GROUP_BIT];
  assign timer_group_reset_b = !state_q.groups[`TIMER_GROUP_BIT];
  assign i2c_reset_b = !state_q.groups[`I2C_GROUP_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_trigger_asserts: assert property (
    wr_access && hit_control && pwdata[7] |=> !group_four_reset_b && $past(state_q.count) == cnt_value)
    else $error("group four reset not asserted or count not loaded");
  chk_i2c_bit_map: assert property (
    wr_access && hit_control && pwdata[0] |=> !i2c_reset_b &&
      timer_group_reset_b == !($past(pwdata[1]) || $past(state_q.groups[1])))
    else $error("bit 0 does not map to the i2c reset");
  chk_release_last: assert property (
    any_active && cnt_value == 16'h0001 && !trigger |=> state_q.groups == 8'h00 && i2c_reset_b)
    else $error("groups not released when countdown ends");
  chk_count_steps: assert property (
    any_active && cnt_value > 16'h0001 && !trigger |=> any_active && cnt_value == $past(cnt_value) - 16'h0001)
    else $error("countdown did not step by one while active");
  chk_hold_eight: assert property (
    trigger && state_q.count == 16'h0008 ##1 !trigger [*8] |-> any_active ##1 !any_active)
    else $error("count of eight did not hold reset for eight cycles");
  chk_count_kept: assert property (
    !(wr_access && hit_count) |=> state_q.count == $past(state_q.count))
    else $error("count register changed without a write");
  chk_read_control: assert property (
    psel && !penable && !pwrite && hit_control |=> prdata[7:0] == $past(state_q.groups))
    else $error("control read does not show live reset state");
  chk_zero_no_effect: assert property (
    wr_access && hit_control && pwdata[7:0] == 8'h00 && !any_active |=> !any_active)
    else $error("writing zero started a reset");
  chk_reserved_zero: assert property (
    state_q.groups[6] == 1'b0 && (!hit_control || prdata[31:8] == 24'h00_0000 || $past(penable)))
    else $error("reserved control bits are set");
  chk_mapped_ok: assert property (
    psel && penable && (paddr == 16'h7010 || paddr == 16'h7014) |-> !pslverr)
    else $error("mapped register answered with an error");

  // Each control bit drives only its own group line
  chk_group_three_map: assert property (
    wr_access && hit_control && pwdata[5] |=> !group_three_reset_b)
    else $error("bit 5 does not map to the group three reset");
  chk_dma_bit_map: assert property (
    wr_access && hit_control && pwdata[4] |=> !dma_reset_b)
    else $error("bit 4 does not map to the dma reset");
  chk_usb_bit_map: assert property (
    wr_access && hit_control && pwdata[3] |=> !usb_reset_b)
    else $error("bit 3 does not map to the usb reset");
  chk_analog_bit_map: assert property (
    wr_access && hit_control && pwdata[2] |=> !analog_group_reset_b)
    else $error("bit 2 does not map to the analog reset");
  chk_timer_bit_map: assert property (
    wr_access && hit_control && pwdata[1] |=> !timer_group_reset_b)
    else $error("bit 1 does not map to the timer reset");

  // Countdown and release
  chk_no_spurious_start: assert property (
    !trigger && !any_active |=> !any_active)
    else $error("a group entered reset without a trigger");
  chk_retrigger_holds: assert property (
    trigger && any_active |=> any_active && cnt_value == $past(state_q.count))
    else $error("retrigger did not reload the countdown");
  chk_release_together: assert property (
    any_active && cnt_last && !trigger |=> {group_four_reset_b, group_three_reset_b, dma_reset_b,
      usb_reset_b, analog_group_reset_b, timer_group_reset_b, i2c_reset_b} == 7'h7f)
    else $error("group lines did not release together");
  chk_count_write: assert property (
    wr_access && hit_count |=> state_q.count == $past(pwdata[15:0]))
    else $error("count write did not land");

  // Register port answers
  chk_zero_wait: assert property (
    psel && penable |-> pready)
    else $error("access phase not answered at once");
  chk_unmapped_err: assert property (
    psel && penable && !hit_count && !hit_control |-> pslverr)
    else $error("unmapped access answered without an error");
  chk_unmapped_read_zero: assert property (
    psel && !penable && !pwrite && !hit_count && !hit_control |=> prdata == 32'h0000_0000)
    else $error("unmapped read did not return zero");
  chk_read_count: assert property (
    psel && !penable && !pwrite && hit_count |=> prdata == {16'h0000, $past(state_q.count)})
    else $error("count read does not show the programmed count");

endmodule : peripheral_soft_reset_ctrl

//--- tb/reset_group_model.sv
// Peripheral groups that receive the reset lines and time each pulse
`timescale 1ns/100ps

module reset_group_model (
  // Clock
  input wire logic clk,
  // Group reset lines, active low
  input wire logic [6:0] lines_b,
  // Length of the last finished pulse per line
  output logic [6:0][15:0] last_len
);
  logic [6:0][15:0] run = '0;

  // Count low cycles; latch the length when the line lets go
  initial last_len = '0;
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (lines_b[i] === 1'b0) begin
        run[i] <= run[i] + 16'h0001;
      end else begin
        if (run[i] != 16'h0000) begin
          last_len[i] <= run[i];
        end
        run[i] <= 16'h0000;
      end
    end
  end
endmodule : reset_group_model

//--- tb/peripheral_soft_reset_ctrl_tb.sv
// Self-checking bench for the peripheral soft reset sequencer
`timescale 1ns/100ps
`include "soft_reset_params.svh"

module peripheral_soft_reset_ctrl_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [15:0] cnt_addr = `CYCLE_COUNT_IDX << 2;
  localparam logic [15:0] ctl_addr = `RESET_CONTROL_IDX << 2;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire [6:0] lines_b;
  logic [6:0][15:0] last_len;
  int mismatches = 0;
  int compares = 0;

  peripheral_soft_reset_ctrl DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group_four_reset_b(lines_b[6]), .group_three_reset_b(lines_b[5]),
    .dma_reset_b(lines_b[4]), .usb_reset_b(lines_b[3]), .analog_group_reset_b(lines_b[2]),
    .timer_group_reset_b(lines_b[1]), .i2c_reset_b(lines_b[0]));

  reset_group_model groups (.clk(clk), .lines_b(lines_b), .last_len(last_len));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // One APB transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-drives psel in this step
    @(posedge clk);
  endtask : apb

  // Program a count, trigger groups, poll and time the release
  task automatic fire(input logic [15:0] c, input logic [15:0] n);
    logic [31:0] rd;
    logic e;
    logic [6:0] g;
    g = {c[7], c[5:0]};
    apb(1'b1, cnt_addr, {16'h0000, n}, rd, e);
    apb(1'b1, ctl_addr, {16'h0000, c}, rd, e);
    apb(1'b0, ctl_addr, 32'h0000_0000, rd, e);
    chk(rd, {24'h00_0000, c[7:0] & `GROUP_BITS_MASK});
    chk({25'h0, lines_b}, {25'h0, ~g});
    // Keep away from the groups until they are released; the watchdog bounds a hang
    while (lines_b !== 7'h7f) begin
      @(posedge clk);
    end
    apb(1'b0, ctl_addr, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      if (g[i]) begin
        chk({16'h0000, last_len[i]}, {16'h0000, n});
      end
    end
    apb(1'b0, cnt_addr, 32'h0000_0000, rd, e);
    chk(rd, {16'h0000, n});
    chk({31'h0, e}, 32'h0000_0000);
  endtask : fire

  // Retrigger during a running reset reloads the count for every active group
  task automatic retrigger();
    logic [31:0] rd;
    logic e;
    apb(1'b1, cnt_addr, 32'h0000_0008, rd, e);
    apb(1'b1, ctl_addr, 32'h0000_0001, rd, e);
    apb(1'b1, ctl_addr, 32'h0000_0002, rd, e);
    apb(1'b0, ctl_addr, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0003);
    while (lines_b !== 7'h7f) begin
      @(posedge clk);
    end
    @(posedge clk);
    // First group ran three transfer cycles before the reload, then eight more
    chk({16'h0000, last_len[0]}, 32'h0000_000b);
    chk({16'h0000, last_len[1]}, 32'h0000_0008);
  endtask : retrigger

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #20000;
    mismatches++;
    final_report();
  end

  initial begin
    logic [31:0] rd;
    logic e;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({25'h0, lines_b}, 32'h0000_007f);
    apb(1'b0, cnt_addr, 32'h0000_0000, rd, e);
    chk(rd, {16'h0000, `CYCLE_COUNT_RESET});
    // Every bit alone, bit 6 included as the reserved case
    for (int b = 0; b < 8; b++) begin
      fire(16'h0001 << b, 16'h0008);
    end
    fire(16'hFF40, 16'h0008);
    fire(16'h00B1, 16'h0013);
    fire(16'h0000, 16'h0008);
    retrigger();
    apb(1'b1, cnt_addr, 32'hABCD_F00D, rd, e);
    apb(1'b0, cnt_addr, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_F00D);
    // Unmapped neighbour: refused, nothing changes
    apb(1'b1, 16'h7018, 32'h0000_00FF, rd, e);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, 16'h7018, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0000);
    apb(1'b0, cnt_addr, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_F00D);
    final_report();
  end
endmodule : peripheral_soft_reset_ctrl_tb
